/* spd_drv.sv */
// Purpose: input decoding of a two-phase stepping driver
// Assumes: mode input is a static setting; link lines asynchronous
// Notes:   excitation state is gray coded and wraps every four steps
`timescale 1ns/1ps

// Overview of operation
// - static input picks two-pulse or pulse-direction mode
// - two-pulse: cw line falling steps clockwise
// - two-pulse: ccw line falling steps counter-clockwise
// - controller never pulses both lines together
// - controller keeps pulse lines off when idle; the ccw line stays on if two-pulse follows a cw one-pulse move
// - one-pulse: direction on, pulse fall steps clockwise
// - one-pulse: direction off, fall steps counter-clockwise
// - controller waits response time after direction change
// - release on removes all winding current
// - release off restores winding current
// - controller releases only for manual shaft turning
// - line high means current flows, logically on
// - selection stable ten microseconds before next pulse
// - pulse rate up to 100 kHz, 50% duty
// - controller waits after release before pulsing
module spd_drv (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_MODE_2P,
    spd_if.drv               LINK,
    output logic             O_STEP,
    output logic             O_STEP_CW,
    output logic             O_PHASE_A,
    output logic             O_PHASE_B,
    output logic             O_WIND_EN,
    output logic      [15:0] O_POS,
    output logic      [3:0]  O_WARN
);
    import spd_pkg::*;
    `include "spd_regs.svh"

    spd_drv_st_t r;
    spd_drv_st_t n;

    logic fall_p;
    logic fall_d;
    logic rel;
    logic req;
    logic req_cw;
    logic bad;
    logic dir_evt;

    // ============================================================
    // helpers
    function automatic logic spd_fall(input logic prev,
                                      input logic cur);
        return prev & ~cur;
    endfunction : spd_fall

    function automatic logic [15:0] spd_sat(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h1;
    endfunction : spd_sat

    // two-bit gray counter keeps one phase change per step
    function automatic logic [1:0] spd_gray_step(input logic [1:0] g,
                                                 input logic cw);
        logic [1:0] b;
        logic [1:0] nb;
        b  = {g[1], g[1] ^ g[0]};
        nb = cw ? b + 2'h1 : b - 2'h1;
        return {nb[1], nb[1] ^ nb[0]};
    endfunction : spd_gray_step

    // an age reads one less than the cycles since its event, so the
    // compare adds one back: a legal full-rate train must not warn
    function automatic logic spd_young(input logic [15:0] age,
                                       input logic [15:0] limit);
        logic [16:0] span;
        span = {1'b0, age} + 17'h1;
        return span < {1'b0, limit};
    endfunction : spd_young

    // two-pulse decode {dropped, request, clockwise}; a fall beside a
    // held-on other line is dropped, as the pair cannot be told apart
    function automatic logic [2:0] spd_dec_2p(input logic fp,
                                              input logic fd,
                                              input logic on_p,
                                              input logic on_d);
        logic [2:0] d;
        d = 3'b000;
        if ((fp && (fd || on_d)) || (fd && on_p)) begin
            d = 3'b100;
        end else if (fp) begin
            d = 3'b011;
        end else if (fd) begin
            d = 3'b010;
        end
        return d;
    endfunction : spd_dec_2p

    // ============================================================
    // decode
    always_comb begin
        n       = r;
        fall_p  = 1'b0;
        fall_d  = 1'b0;
        req     = 1'b0;
        req_cw  = 1'b0;
        bad     = 1'b0;
        dir_evt = 1'b0;
        // ========================================================
        // synchroniser
        // two flops: the isolators switch with no regard to this clock
        // high on a line means current in the isolator
        n.sync1 = {LINK.windings_release_in,
                   LINK.ccw_dir_in,
                   LINK.step_pulse_in};
        n.sync2 = r.sync1;
        n.prev  = r.sync2;
        for (int i = 0; i < 3; i++) begin
            n.prev[i] = r.sync2[i];
        end
        // three cycles of latency against 50 per half period
        fall_p = spd_fall(r.prev[`SPD_LN_PULSE], r.sync2[`SPD_LN_PULSE]);
        fall_d = spd_fall(r.prev[`SPD_LN_DIR], r.sync2[`SPD_LN_DIR]);
        rel    = r.sync2[`SPD_LN_REL];

        // ========================================================
        // step decode
        if (I_MODE_2P) begin
            {bad, req, req_cw} = spd_dec_2p(fall_p, fall_d,
                                            r.sync2[`SPD_LN_PULSE],
                                            r.sync2[`SPD_LN_DIR]);
        end else if (fall_p) begin
            // one-pulse: the direction level picks the way
            req    = 1'b1;
            req_cw = r.sync2[`SPD_LN_DIR];
        end

        // ========================================================
        // windings and position
        n.wind_en = ~rel;
        // release wins over a step seen in the same cycle
        n.step    = req & ~rel;
        n.step_cw = req_cw & req & ~rel;
        if (req && !rel) begin
            n.exc     = spd_gray_step(r.exc, req_cw);
            n.pos     = req_cw ? r.pos + 16'h1 : r.pos - 16'h1;
            n.last_cw = req_cw;
        end

        // ========================================================
        // timing watch on the far side, warnings only
        n.warn = 4'h0;
        n.warn[`SPD_WARN_CONFLICT] = bad;
        n.dir_age = spd_sat(r.dir_age);
        n.rel_age = spd_sat(r.rel_age);
        n.per_age = spd_sat(r.per_age);
        // two-pulse has no direction line: each step restarts the age
        if (I_MODE_2P) begin
            dir_evt = req;
        end else begin
            dir_evt = r.prev[`SPD_LN_DIR] != r.sync2[`SPD_LN_DIR];
        end
        if (dir_evt) begin
            n.dir_age = 16'h0;
        end
        if (rel) begin
            n.rel_age = 16'h0;
        end
        if (req && !rel) begin
            n.per_age = 16'h0;
            // the watch counts from the fall, so it is looser
            // than the true select-to-pulse figure by one half
            if (req_cw != r.last_cw
                && spd_young(r.dir_age, `SPD_RESP_CYC)) begin
                n.warn[`SPD_WARN_DIRFAST] = 1'b1;
            end
            if (spd_young(r.rel_age, `SPD_RELWAIT_CYC)) begin
                n.warn[`SPD_WARN_RELFAST] = 1'b1;
            end
            if (spd_young(r.per_age, `SPD_PERIOD_CYC)) begin
                n.warn[`SPD_WARN_OVERRATE] = 1'b1;
            end
        end
        if (rel) begin
            n.warn[`SPD_WARN_RELFAST] = 1'b0;
        end
    end

    // ============================================================
    // state register
    // age counters start saturated-free at zero, so the first
    // steps after reset may warn; warnings do not block steps
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ============================================================
    // outputs, each a field of the state register
    // phases leave the gray state directly: one moves per step
    assign O_STEP    = r.step;
    assign O_STEP_CW = r.step_cw;
    assign O_PHASE_A = r.exc[1];
    assign O_PHASE_B = r.exc[0];
    assign O_WIND_EN = r.wind_en;
    assign O_POS     = r.pos;
    assign O_WARN    = r.warn;

endmodule : spd_drv

/* spd_regs.svh */
// Purpose: shared constants of the step pulse decoder and its controller
// Assumes: 10 MHz clock
// Notes:   counts are derived from times in ns, rounded up
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// ============================================================
// controller register map
`define SPD_ADDR_CTRL       8'h00
`define SPD_ADDR_MOVE       8'h04
`define SPD_ADDR_STAT       8'h08
`define SPD_CTRL_MODE2P_BIT 0
`define SPD_CTRL_REL_BIT    1
`define SPD_MOVE_DIRCW_BIT  16
`define SPD_STAT_BUSY_BIT   0
`define SPD_STAT_REL_BIT    1
`define SPD_STAT_HOLD_BIT   2

// ============================================================
// link line positions inside the sync vectors
`define SPD_LN_PULSE        0
`define SPD_LN_DIR          1
`define SPD_LN_REL          2

// ============================================================
// driver warning bits
`define SPD_WARN_CONFLICT   0
`define SPD_WARN_DIRFAST    1
`define SPD_WARN_RELFAST    2
`define SPD_WARN_OVERRATE   3

// ============================================================
// timing
`define SPD_CLK_KHZ         10000
`define SPD_RESP_NS         10000
`define SPD_HALF_NS         5000
`define SPD_PERIOD_NS       10000
`define SPD_RELWAIT_NS      100000
`define SPD_NS2CYC(ns)      (((ns) * `SPD_CLK_KHZ + 999999) / 1000000)
`define SPD_RESP_CYC        16'(`SPD_NS2CYC(`SPD_RESP_NS))
`define SPD_HALF_CYC        16'(`SPD_NS2CYC(`SPD_HALF_NS))
`define SPD_PERIOD_CYC      16'(`SPD_NS2CYC(`SPD_PERIOD_NS))
`define SPD_RELWAIT_CYC     16'(`SPD_NS2CYC(`SPD_RELWAIT_NS))

// ============================================================
// reset values
`define SPD_CTRL_RST        2'h0
`define SPD_WIND_RST        1'b0

`endif

/* spd_pkg.sv */
// Purpose: types of the step pulse decoder and its controller
// Assumes: nothing
// Notes:   driver and controller each keep all their state in one struct
package spd_pkg;

    // ============================================================
    // controller sequence, gray along idle-setup-on-off
    typedef enum logic [2:0] {
        SPD_HS_IDLE  = 3'b000,
        SPD_HS_SETUP = 3'b001,
        SPD_HS_ON    = 3'b011,
        SPD_HS_OFF   = 3'b010,
        SPD_HS_HOLD  = 3'b110
    } spd_hst_state_t;

    // ============================================================
    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  prev;
        logic        step;
        logic        step_cw;
        logic [1:0]  exc;
        logic [15:0] pos;
        logic        wind_en;
        logic        last_cw;
        logic [15:0] dir_age;
        logic [15:0] rel_age;
        logic [15:0] per_age;
        logic [3:0]  warn;
    } spd_drv_st_t;

    // ============================================================
    typedef struct packed {
        spd_hst_state_t st;
        logic [15:0]    tmr;
        logic [15:0]    remain;
        logic           dir_cw;
        logic           mode2p;
        logic           rel;
        logic           pulse_on;
        logic           dir_on;
        logic           rel_on;
        logic           busy;
        logic [31:0]    rdata;
    } spd_hst_st_t;

endpackage : spd_pkg

/* spd_if.sv */
// Purpose: isolated input lines from controller to driver
// Assumes: 1 means current flows in the isolating element
// Notes:   no clocking block, the driver synchronises
`timescale 1ns/1ps
interface spd_if;
    logic step_pulse_in;
    logic ccw_dir_in;
    logic windings_release_in;

    modport ctrl (
        output step_pulse_in,
        output ccw_dir_in,
        output windings_release_in
    );

    modport drv (
        input  step_pulse_in,
        input  ccw_dir_in,
        input  windings_release_in
    );
endinterface : spd_if

/* spd_hst.sv */
// Purpose: pulse train controller end of the stepping link
// Assumes: one clock, software port with read data one cycle later
// Notes:   a move is a count of steps in one direction
`timescale 1ns/1ps
module spd_hst (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    output logic             O_BUSY,
    spd_if.ctrl              LINK
);
    import spd_pkg::*;
    `include "spd_regs.svh"

    spd_hst_st_t r;
    spd_hst_st_t n;

    function automatic logic [31:0] spd_rd(input spd_hst_st_t s,
                                           input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            `SPD_ADDR_CTRL: begin
                d[`SPD_CTRL_MODE2P_BIT] = s.mode2p;
                d[`SPD_CTRL_REL_BIT]    = s.rel;
            end
            `SPD_ADDR_MOVE: begin
                d[15:0]                 = s.remain;
                d[`SPD_MOVE_DIRCW_BIT]  = s.dir_cw;
            end
            `SPD_ADDR_STAT: begin
                d[`SPD_STAT_BUSY_BIT]   = (s.st != SPD_HS_IDLE);
                d[`SPD_STAT_REL_BIT]    = s.rel;
                d[`SPD_STAT_HOLD_BIT]   = (s.st == SPD_HS_HOLD);
            end
            default: d = 32'h0;
        endcase
        return d;
    endfunction : spd_rd

    // ============================================================
    // sequence
    always_comb begin
        n       = r;
        n.rdata = I_RD ? spd_rd(r, I_ADDR) : 32'h0;
        case (r.st)
            SPD_HS_IDLE: begin
                if (I_WR && I_ADDR == `SPD_ADDR_MOVE && !r.rel
                    && I_WDATA[15:0] != 16'h0) begin
                    n.remain = I_WDATA[15:0];
                    n.dir_cw = I_WDATA[`SPD_MOVE_DIRCW_BIT];
                    n.tmr    = `SPD_RESP_CYC;
                    n.st     = SPD_HS_SETUP;
                    n.dir_on = !r.mode2p && I_WDATA[`SPD_MOVE_DIRCW_BIT];
                end
            end
            SPD_HS_SETUP: begin
                n.tmr = r.tmr - 16'h1;
                if (r.tmr == 16'h1) begin
                    n.st  = SPD_HS_ON;
                    n.tmr = `SPD_HALF_CYC;
                    if (r.mode2p && !r.dir_cw) begin
                        n.dir_on   = 1'b1;
                    end else begin
                        n.pulse_on = 1'b1;
                    end
                end
            end
            SPD_HS_ON: begin
                n.tmr = r.tmr - 16'h1;
                if (r.tmr == 16'h1) begin
                    n.st       = SPD_HS_OFF;
                    n.tmr      = `SPD_HALF_CYC;
                    n.remain   = r.remain - 16'h1;
                    n.pulse_on = 1'b0;
                    n.dir_on   = !r.mode2p && r.dir_cw;
                end
            end
            SPD_HS_OFF: begin
                n.tmr = r.tmr - 16'h1;
                if (r.tmr == 16'h1) begin
                    if (r.remain == 16'h0) begin
                        n.st = SPD_HS_IDLE;
                    end else begin
                        n.st  = SPD_HS_ON;
                        n.tmr = `SPD_HALF_CYC;
                        if (r.mode2p && !r.dir_cw) begin
                            n.dir_on   = 1'b1;
                        end else begin
                            n.pulse_on = 1'b1;
                        end
                    end
                end
            end
            SPD_HS_HOLD: begin
                // no pulses straight after the windings come back
                n.tmr = r.tmr - 16'h1;
                if (r.tmr == 16'h1) begin
                    n.st = SPD_HS_IDLE;
                end
            end
            default: n.st = SPD_HS_IDLE;
        endcase
        if (I_WR && I_ADDR == `SPD_ADDR_CTRL) begin
            if (r.st == SPD_HS_IDLE) begin
                n.mode2p = I_WDATA[`SPD_CTRL_MODE2P_BIT];
            end
            n.rel = I_WDATA[`SPD_CTRL_REL_BIT];
            if (I_WDATA[`SPD_CTRL_REL_BIT]) begin
                // release aborts a move: turning the shaft by hand
                n.st       = SPD_HS_IDLE;
                n.remain   = 16'h0;
                n.pulse_on = 1'b0;
                n.dir_on   = 1'b0;
            end else if (r.rel) begin
                n.st  = SPD_HS_HOLD;
                n.tmr = `SPD_RELWAIT_CYC;
            end
        end
        n.rel_on = n.rel;
        n.busy   = (n.st != SPD_HS_IDLE);
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign O_RDATA                  = r.rdata;
    assign O_BUSY                   = r.busy;
    assign LINK.step_pulse_in       = r.pulse_on;
    assign LINK.ccw_dir_in          = r.dir_on;
    assign LINK.windings_release_in = r.rel_on;

endmodule : spd_hst

/* spd_link_monitor.sv */
// Purpose: watch the link between controller and driver
// Assumes: link lines change just after a clock edge
// Notes:   a step shows three sampled edges after its fall
`timescale 1ns/1ps
module spd_link_monitor (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_MODE_2P,
    input  wire logic        step_pulse_in,
    input  wire logic        ccw_dir_in,
    input  wire logic        windings_release_in,
    input  wire logic        O_STEP,
    input  wire logic        O_STEP_CW,
    input  wire logic        O_PHASE_A,
    input  wire logic        O_PHASE_B,
    input  wire logic        O_WIND_EN,
    input  wire logic [15:0] O_POS
);
    logic       pls_q;
    logic       dir_q;
    logic [7:0] dir_age;
    logic       quiet;

    assign quiet = !windings_release_in && O_WIND_EN;

    // =========
    // helpers
    // age saturates: only the first hundred cycles matter
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            pls_q   <= 1'b0;
            dir_q   <= 1'b0;
            dir_age <= 8'h00;
        end else begin
            pls_q <= step_pulse_in;
            dir_q <= ccw_dir_in;
            if (ccw_dir_in != dir_q) dir_age <= 8'h00;
            else if (dir_age != 8'hFF) dir_age <= dir_age + 8'h01;
        end
    end

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    // =========
    // assertions
    a_cw_line_step: assert property (
        I_MODE_2P && pls_q && !step_pulse_in && !ccw_dir_in && !dir_q
        && quiet |-> ##3 O_STEP && O_STEP_CW) else $error("cw step lost");
    a_ccw_line_step: assert property (
        I_MODE_2P && dir_q && !ccw_dir_in && !step_pulse_in && !pls_q
        && quiet |-> ##3 O_STEP && !O_STEP_CW) else $error("ccw step lost");
    a_dir_step: assert property (
        !I_MODE_2P && pls_q && !step_pulse_in && quiet
        |-> ##3 O_STEP && O_STEP_CW == $past(ccw_dir_in, 3))
        else $error("pulse step wrong");
    a_step_cause: assert property (
        O_STEP |-> $past(pls_q, 3) && !$past(step_pulse_in, 3)
        || I_MODE_2P && $past(dir_q, 3) && !$past(ccw_dir_in, 3))
        else $error("step without fall");
    a_pos_track: assert property (
        O_STEP |-> O_POS == $past(O_POS) + (O_STEP_CW ? 16'h0001 : 16'hFFFF))
        else $error("position off");
    a_pos_hold: assert property (
        !O_STEP |-> $stable(O_POS)) else $error("position moved");
    a_phase_walk: assert property (
        O_STEP |-> {O_PHASE_A, O_PHASE_B} == (O_STEP_CW ?
        {$past(O_PHASE_B), !$past(O_PHASE_A)} :
        {!$past(O_PHASE_B), $past(O_PHASE_A)})) else $error("phase off");
    a_release_off: assert property (
        $rose(windings_release_in) |-> ##3 !O_WIND_EN)
        else $error("current not removed");
    a_release_on: assert property (
        $fell(windings_release_in) |-> ##3 O_WIND_EN)
        else $error("current not restored");
    a_dir_settle: assert property (
        !I_MODE_2P && $rose(step_pulse_in) |-> dir_age >= 8'h63)
        else $error("direction too fresh");
endmodule : spd_link_monitor

/* tb.sv */
// Purpose: drive controller registers, check driver at far end
// Assumes: both ends share one clock
// Notes:   a spare driver takes hand-made faulty link traffic
`timescale 1ns/1ps
`include "spd_regs.svh"
module tb;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        mode = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [31:0] rdata;
    logic        busy, step, step_cw, ph_a, ph_b, wind, step_b, wind_b;
    logic [15:0] pos, pos_b;
    logic [3:0]  warn_a, warn_b;
    logic [3:0]  seen_a = 4'h0, seen_b = 4'h0;
    logic [31:0] v;
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          n_cw = 0, n_ccw = 0, n_b = 0, n_conf = 0;

    spd_if link_a ();
    spd_if link_b ();
    always #50 mclk = ~mclk;

    spd_hst spd_hst_i (.I_MCLK(mclk), .I_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
        .O_BUSY(busy), .LINK(link_a));
    spd_drv spd_drv_i (.I_MCLK(mclk), .I_RST(rst), .I_MODE_2P(mode),
        .LINK(link_a), .O_STEP(step), .O_STEP_CW(step_cw),
        .O_PHASE_A(ph_a), .O_PHASE_B(ph_b), .O_WIND_EN(wind),
        .O_POS(pos), .O_WARN(warn_a));
    // spare driver: its link is driven by hand, faults included
    spd_drv spd_drv_x_i (.I_MCLK(mclk), .I_RST(rst), .I_MODE_2P(mode),
        .LINK(link_b), .O_STEP(step_b), .O_STEP_CW(), .O_PHASE_A(),
        .O_PHASE_B(), .O_WIND_EN(wind_b), .O_POS(pos_b), .O_WARN(warn_b));
    spd_link_monitor spd_link_monitor_i (.I_MCLK(mclk), .I_RST(rst),
        .I_MODE_2P(mode), .step_pulse_in(link_a.step_pulse_in),
        .ccw_dir_in(link_a.ccw_dir_in),
        .windings_release_in(link_a.windings_release_in), .O_STEP(step),
        .O_STEP_CW(step_cw), .O_PHASE_A(ph_a), .O_PHASE_B(ph_b),
        .O_WIND_EN(wind), .O_POS(pos));

    // =========
    // tasks
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge mclk);
        wr_s  <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : reg_rd

    // busy is polled; the cycle ceiling bounds the wait
    task automatic wait_idle();
        tick(4);
        while (busy !== 1'b0) @(posedge mclk);
    endtask : wait_idle

    task automatic drive_b(logic p, logic c, logic r);
        @(posedge mclk);
        link_b.step_pulse_in       <= p;
        link_b.ccw_dir_in          <= c;
        link_b.windings_release_in <= r;
        tick(10);
    endtask : drive_b

    // =========
    // step counting and ceiling
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (step === 1'b1 && step_cw === 1'b1) n_cw <= n_cw + 1;
        if (step === 1'b1 && step_cw === 1'b0) n_ccw <= n_ccw + 1;
        if (step_b === 1'b1) n_b <= n_b + 1;
        if (warn_b[0] === 1'b1) n_conf <= n_conf + 1;
        if (!rst) seen_a <= seen_a | warn_a;
        if (!rst) seen_b <= seen_b | warn_b;
        if (cycles == 8000) begin
            mismatches++;
            give_verdict();
        end
    end

    // =========
    // sequence
    initial begin
        link_b.step_pulse_in = 1'b0;
        link_b.ccw_dir_in = 1'b0;
        link_b.windings_release_in = 1'b0;
        tick(16);
        rst <= 1'b0;
        tick(5);
        chk("wind", 32'h1, wind);
        reg_rd(`SPD_ADDR_CTRL, v);
        chk("ctrl", 32'h0, v);
        reg_rd(8'h0C, v);
        chk("unmapped", 32'h0, v);
        // pulse plus direction: three cw, two ccw
        reg_wr(`SPD_ADDR_MOVE, 32'h0001_0003);
        wait_idle();
        reg_wr(`SPD_ADDR_MOVE, 32'h0000_0002);
        wait_idle();
        chk("cw steps", 32'h3, n_cw);
        chk("ccw steps", 32'h2, n_ccw);
        chk("position", 32'h1, pos);
        chk("phase", 32'h1, {ph_a, ph_b});
        // two-pulse: direction line must end low first, done above
        mode <= 1'b1;
        reg_wr(`SPD_ADDR_CTRL, 32'h1);
        reg_wr(`SPD_ADDR_MOVE, 32'h0001_0002);
        wait_idle();
        reg_wr(`SPD_ADDR_MOVE, 32'h0000_0001);
        wait_idle();
        reg_wr(`SPD_ADDR_MOVE, 32'h0001_0000);
        tick(3);
        chk("busy on zero count", 32'h0, busy);
        chk("idle lines", 32'h0, 32'({link_a.windings_release_in,
            link_a.ccw_dir_in, link_a.step_pulse_in}));
        chk("cw steps", 32'h5, n_cw);
        chk("ccw steps", 32'h3, n_ccw);
        chk("position", 32'h2, pos);
        // release in mid-move after two steps
        reg_wr(`SPD_ADDR_MOVE, 32'h0001_0005);
        tick(260);
        reg_wr(`SPD_ADDR_CTRL, 32'h3);
        tick(5);
        chk("wind off", 32'h0, wind);
        reg_wr(`SPD_ADDR_MOVE, 32'h0001_0001);
        tick(300);
        chk("frozen position", 32'h4, pos);
        reg_rd(`SPD_ADDR_STAT, v);
        chk("status", 32'h2, v);
        reg_wr(`SPD_ADDR_CTRL, 32'h1);
        tick(5);
        chk("wind on", 32'h1, wind);
        reg_rd(`SPD_ADDR_STAT, v);
        chk("hold status", 32'h5, v);
        @(negedge mclk);
        chk("read data gone", 32'h0, rdata);
        tick(900);
        chk("busy in hold", 32'h1, busy);
        tick(200);
        chk("busy after hold", 32'h0, busy);
        // spare link: cw falls while ccw is on
        drive_b(1'b0, 1'b1, 1'b0);
        drive_b(1'b1, 1'b1, 1'b0);
        drive_b(1'b0, 1'b1, 1'b0);
        chk("conflict warning", 32'h1, n_conf);
        chk("conflict steps", 32'h0, n_b);
        drive_b(1'b0, 1'b0, 1'b0);
        chk("spare position", 32'hFFFF, pos_b);
        drive_b(1'b0, 1'b0, 1'b1);
        drive_b(1'b1, 1'b0, 1'b1);
        drive_b(1'b0, 1'b0, 1'b1);
        chk("spare wind", 32'h0, wind_b);
        chk("released position", 32'hFFFF, pos_b);
        drive_b(1'b0, 1'b0, 1'b0);
        drive_b(1'b1, 1'b0, 1'b0);
        drive_b(1'b0, 1'b0, 1'b0);
        chk("step after release", 32'h0, pos_b);
        chk("rate warnings", 32'h0, 32'(seen_a & 4'hA));
        chk("spare warnings", 32'hF, 32'(seen_b));
        give_verdict();
    end
endmodule : tb
